// >>> inc/bec_pkg.sv
// shared constants and types for the bit error rate checker
package bec_pkg;
   // counter and field widths
   localparam int CNT_W      = 24;
   localparam int DLY_W      = 4;
   localparam int BDLY_W     = 5;
   localparam int CYC_W      = 8;
   // timing, own unit first, then cycles at the main clock
   localparam int MCLK_NS    = 25;
   localparam int T1_NS      = 100;   // trigger to active rise
   localparam int T2_NS      = 100;   // pulse fall to active fall
   localparam int PULSE_NS   = 200;   // result pulse width
   localparam int T1_CYC     = (T1_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int T2_CYC     = (T2_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int PULSE_CYC  = (PULSE_NS + MCLK_NS - 1) / MCLK_NS;
   // reference sequence and run ignoring
   localparam int RUN_IGNORE = 160;
   localparam int SEED_LEN   = 9;
   localparam int TAP_HI     = 8;     // x^9 stage
   localparam int TAP_LO     = 4;     // x^5 stage
   localparam logic [8:0] PRBS_RST = 9'h1FF;
   localparam logic [7:0] RUN_RST  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;

   // one-hot sequencer states
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_ARM     = 7'h02,
      ST_DISCARD = 7'h04,
      ST_SYNC    = 7'h08,
      ST_MEAS    = 7'h10,
      ST_PULSE   = 7'h20,
      ST_TAIL    = 7'h40
   } bec_state_t;

   // configuration bits, all static during a sequence
   typedef struct packed {
      logic              gate_en;
      logic              gate_pos;
      logic              clk_dly_en;
      logic [DLY_W-1:0]  clk_dly;
      logic              gate_dly_en;
      logic [DLY_W-1:0]  gate_dly;
      logic              bit_dly_en;
      logic [BDLY_W-1:0] bit_dly;
      logic              resync_en;
      logic [CNT_W-1:0]  resync_limit;
      logic              ign_en;
      logic              ign_val;
      logic              fail_hold;
      logic [CNT_W-1:0]  err_limit;
      logic [CNT_W-1:0]  total_bits;
      logic [CYC_W-1:0]  cycles;
   } bec_cfg_t;

   // status readback
   typedef struct packed {
      logic              busy;
      logic              locked;
      logic              verdict_valid;
      logic              fail;
      logic [CNT_W-1:0]  err_cnt;
      logic [CNT_W-1:0]  bit_cnt;
      logic [CYC_W-1:0]  cycle_done;
   } bec_stat_t;
endpackage : bec_pkg

// >>> design/bec_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module bec_sync #(
   parameter int W = 3
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst_b,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);
   import bec_pkg::*;

   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   logic [W-1:0] agree;

   // first stage feeds only the second
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         ff1 <= '0;
         ff2 <= '0;
         ff3 <= '0;
      end else begin
         ff1 <= i_async;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   assign agree = ~(ff2 ^ ff3);

   // level follows only where stages two and three agree
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_level <= '0;
      end else begin
         o_level <= (ff2 & agree) | (o_level & ~agree);
      end
   end
endmodule : bec_sync

// >>> design/bec_checker.sv
// bit error rate checker core
//
// Function
// - gate on: accept clock only while gated
// - polarity picks high or low gate
// - gate off: every rising clock edge counts
// - programmable clock delay, shown on pulse pin
// - gate delayed by programmed clock periods
// - trigger starts measurement and synchronisation
// - continuous sequences only, framed or not
// - resync restarts when errors exceed limit, only in runs of at most one cycle
// - long runs of the ignore value never count errors
// - ignored bits still count as received
// - cycle-end mode judges each cycle fresh
// - fail-hold keeps fail for whole loop
// - repeat cycles synchronise only once
// - lock kept until a new sequence or a resync
// - active high while measuring, triggers ignored
// - busy state readable in status
// - active rises and falls after handling times
// - result pulse ends before active falls
`timescale 1ns/10ps
module bec_checker #(
   parameter int DLY_DEPTH = 16
) (
   input  wire logic              i_mclk,
   input  wire logic              i_rst_b,
   input  wire logic              i_meas_clk,
   input  wire logic              i_data,
   input  wire logic              i_gate,
   input  wire logic              i_trig,
   input  wire bec_pkg::bec_cfg_t i_cfg,
   output logic                   o_meas_active,
   output logic                   o_result_pulse,
   output bec_pkg::bec_stat_t     o_status
);
   import bec_pkg::*;

   localparam int A_T1 = T1_CYC;
   localparam int A_T2 = T2_CYC;

   bec_state_t           st;
   logic [2:0]           lvl;
   logic                 clk_lvl;
   logic                 gate_lvl;
   logic                 rx;
   logic [DLY_DEPTH-1:0] clk_line;
   logic [DLY_DEPTH-1:0] gate_line;
   logic                 clk_q;
   logic                 clk_del;
   logic                 clk_del_q;
   logic                 gate_sel;
   logic                 gate_ok;
   logic                 raw_rise;
   logic                 acc_bit;
   logic [8:0]           lfsr;
   logic                 pred;
   logic                 mis;
   logic                 locked;
   logic [BDLY_W+4:0]    ok_cnt;
   logic [3:0]           seed_cnt;
   logic [BDLY_W+4:0]    lock_len;
   logic [7:0]           t_cnt;
   logic [BDLY_W-1:0]    disc_cnt;
   logic [CNT_W-1:0]     bit_cnt;
   logic [CNT_W-1:0]     err_cnt;
   logic [7:0]           run_len;
   logic [CNT_W-1:0]     run_err;
   logic [CYC_W-1:0]     cyc_done;
   logic                 fail;
   logic                 vvalid;
   logic                 meas_bit;
   logic                 is_ign;
   logic                 last_bit;
   logic                 resync_hit;
   logic                 fail_now;
   logic                 lock_hit;
   logic [CNT_W-1:0]     next_err;
   logic [CNT_W-1:0]     next_run_err;
   logic [7:0]           next_run_len;
   logic [CNT_W-1:0]     flush_err;

   // clock, gate and data pins enter through the synchroniser
   bec_sync #(.W(3)) u_sync (
      .i_mclk  (i_mclk),
      .i_rst_b (i_rst_b),
      .i_async ({i_meas_clk, i_gate, i_data}),
      .o_level (lvl)
   );

   assign clk_lvl  = lvl[2];
   assign gate_lvl = lvl[1];
   assign rx       = lvl[0];

   // clock delay line and gate history in clock periods
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         clk_line  <= '0;
         gate_line <= '0;
         clk_q     <= 1'b0;
         clk_del_q <= 1'b0;
      end else begin
         clk_line  <= {clk_line[DLY_DEPTH-2:0], clk_lvl};
         clk_q     <= clk_lvl;
         clk_del_q <= clk_del;
         if (raw_rise) begin
            gate_line <= {gate_line[DLY_DEPTH-2:0], gate_lvl};
         end
      end
   end

   // sampling edge selection and gating
   assign raw_rise = clk_lvl & ~clk_q;
   assign clk_del  = i_cfg.clk_dly_en ? clk_line[i_cfg.clk_dly] : clk_lvl;
   // delay 0 is the gate at this very edge, delay n the gate n clock rises back
   assign gate_sel = (i_cfg.gate_dly_en && i_cfg.gate_dly != '0)
                     ? gate_line[i_cfg.gate_dly - 1'b1] : gate_lvl;
   assign gate_ok  = !i_cfg.gate_en || (gate_sel == i_cfg.gate_pos);
   assign acc_bit  = clk_del & ~clk_del_q & gate_ok;

   // reference prediction, only continuous sequences track
   assign pred     = lfsr[TAP_HI] ^ lfsr[TAP_LO];
   assign mis      = rx ^ pred;
   assign lock_len = (BDLY_W+5)'(SEED_LEN) + (i_cfg.bit_dly_en ? (BDLY_W+5)'(i_cfg.bit_dly) : '0);
   assign lock_hit = (st == ST_SYNC) && acc_bit && (seed_cnt == 4'(SEED_LEN))
                     && !mis && (ok_cnt + 1'b1 == lock_len);
   assign meas_bit = (st == ST_MEAS) && acc_bit;
   assign is_ign   = i_cfg.ign_en && (rx == i_cfg.ign_val);
   assign last_bit = meas_bit && (bit_cnt + 1'b1 >= i_cfg.total_bits);
   assign resync_hit = (st == ST_MEAS) && i_cfg.resync_en && (i_cfg.cycles <= 8'h01)
                       && (err_cnt > i_cfg.resync_limit);

   // reference generator: seeds from data, then free-runs
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         lfsr     <= PRBS_RST;
         locked   <= 1'b0;
         seed_cnt <= '0;
         ok_cnt   <= '0;
      end else if ((st == ST_IDLE && i_trig) || resync_hit) begin
         locked   <= 1'b0;
         seed_cnt <= '0;
         ok_cnt   <= '0;
      end else if (st == ST_SYNC && acc_bit) begin
         lfsr <= {lfsr[7:0], rx};
         if (seed_cnt != 4'(SEED_LEN)) begin
            seed_cnt <= seed_cnt + 1'b1;
         end else if (mis) begin
            ok_cnt <= '0;
         end else begin
            ok_cnt <= ok_cnt + 1'b1;
         end
         if (lock_hit) begin
            locked <= 1'b1;
         end
      end else if (locked && acc_bit) begin
         lfsr <= {lfsr[7:0], pred};
      end
   end

   // error and run accounting for one accepted bit
   always_comb begin
      next_err     = err_cnt;
      next_run_err = run_err;
      next_run_len = run_len;
      if (meas_bit) begin
         if (is_ign) begin
            if (run_len != 8'(RUN_IGNORE)) begin
               next_run_len = run_len + 1'b1;
            end
            next_run_err = run_err + CNT_W'(mis);
         end else begin
            if (run_len < 8'(RUN_IGNORE)) begin
               next_err = err_cnt + run_err;
            end
            next_err     = next_err + CNT_W'(mis);
            next_run_err = '0;
            next_run_len = RUN_RST;
         end
      end
      flush_err = (next_run_len < 8'(RUN_IGNORE)) ? next_err + next_run_err : next_err;
   end

   assign fail_now = flush_err > i_cfg.err_limit;

   // counters of the running cycle
   always_ff @(posedge i_mclk) begin
      // results of the last cycle stand until the next trigger
      if (!i_rst_b || (st == ST_IDLE && i_trig) || st == ST_SYNC
          || (st == ST_PULSE && t_cnt == 8'(PULSE_CYC - 1) && cyc_done < i_cfg.cycles)) begin
         bit_cnt <= CNT_RST;
         err_cnt <= CNT_RST;
         run_err <= CNT_RST;
         run_len <= RUN_RST;
      end else if (meas_bit) begin
         bit_cnt <= bit_cnt + 1'b1;
         err_cnt <= next_err;
         run_err <= next_run_err;
         run_len <= next_run_len;
      end
   end

   // verdict per cycle or held over the loop
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         fail   <= 1'b0;
         vvalid <= 1'b0;
      end else if (st == ST_IDLE && i_trig) begin
         fail   <= 1'b0;
         vvalid <= 1'b0;
      end else if (last_bit) begin
         fail   <= i_cfg.fail_hold ? (fail | fail_now) : fail_now;
         vvalid <= 1'b1;
      end
   end

   // sequencer
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         st       <= ST_IDLE;
         t_cnt    <= '0;
         disc_cnt <= '0;
         cyc_done <= '0;
      end else begin
         unique case (st)
            ST_IDLE: begin
               t_cnt    <= '0;
               disc_cnt <= '0;
               if (i_trig) begin
                  st       <= ST_ARM;
                  cyc_done <= '0;
               end
            end
            ST_ARM: begin
               t_cnt <= t_cnt + 1'b1;
               if (t_cnt == 8'(T1_CYC - 1)) begin
                  st <= (i_cfg.bit_dly_en && i_cfg.bit_dly != '0) ? ST_DISCARD : ST_SYNC;
               end
            end
            ST_DISCARD: begin
               if (acc_bit) begin
                  disc_cnt <= disc_cnt + 1'b1;
                  if (disc_cnt + 1'b1 == i_cfg.bit_dly) begin
                     st <= ST_SYNC;
                  end
               end
            end
            ST_SYNC: begin
               if (lock_hit) begin
                  st <= ST_MEAS;
               end
            end
            ST_MEAS: begin
               t_cnt <= '0;
               if (resync_hit) begin
                  st <= ST_SYNC;
               end else if (last_bit) begin
                  st       <= ST_PULSE;
                  cyc_done <= cyc_done + 1'b1;
               end
            end
            ST_PULSE: begin
               t_cnt <= t_cnt + 1'b1;
               if (t_cnt == 8'(PULSE_CYC - 1)) begin
                  t_cnt <= '0;
                  st    <= (cyc_done < i_cfg.cycles) ? ST_MEAS : ST_TAIL;
               end
            end
            ST_TAIL: begin
               t_cnt <= t_cnt + 1'b1;
               if (t_cnt == 8'(T2_CYC - 1)) begin
                  st <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // pins and status straight from flops
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_meas_active  <= 1'b0;
         o_result_pulse <= 1'b0;
         o_status       <= '0;
      end else begin
         if (st == ST_ARM && t_cnt == 8'(T1_CYC - 1)) begin
            o_meas_active <= 1'b1;
         end else if (st == ST_TAIL && t_cnt == 8'(T2_CYC - 1)) begin
            o_meas_active <= 1'b0;
         end
         if (st == ST_MEAS && last_bit) begin
            o_result_pulse <= 1'b1;
         end else if (st == ST_PULSE) begin
            o_result_pulse <= (t_cnt != 8'(PULSE_CYC - 1)) || (cyc_done < i_cfg.cycles
                              && i_cfg.clk_dly_en && clk_del & gate_ok);
         end else begin
            o_result_pulse <= i_cfg.clk_dly_en && (st == ST_MEAS || st == ST_SYNC
                              || st == ST_DISCARD) && clk_del && gate_ok;
         end
         o_status <= '{busy: o_meas_active, locked: locked, verdict_valid: vvalid,
                       fail: fail, err_cnt: err_cnt, bit_cnt: bit_cnt,
                       cycle_done: cyc_done};
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   sequence s_arm;
      st == ST_IDLE && i_trig;
   endsequence

   sequence s_rise;
      ##A_T1 !o_meas_active ##1 o_meas_active;
   endsequence

   sequence s_tail;
      ##(A_T2 - 1) o_meas_active ##1 !o_meas_active;
   endsequence

   a_active_rise: assert property (s_arm |-> s_rise)
      else $error("active did not rise after handling time");
   a_trig_ignore: assert property (st == ST_MEAS && i_trig |=> st != ST_ARM)
      else $error("trigger taken while busy");
   a_active_fall: assert property ($fell(o_result_pulse) && st == ST_TAIL |-> s_tail)
      else $error("active fall not after pulse fall");
   a_pulse_width: assert property ($rose(st == ST_PULSE) && !i_cfg.clk_dly_en
      |-> o_result_pulse[*8] ##1 !o_result_pulse)
      else $error("result pulse width wrong");
   a_gate_block: assert property (i_cfg.gate_en && gate_sel != i_cfg.gate_pos |-> !acc_bit)
      else $error("bit accepted outside gate");
   a_gate_off: assert property (!i_cfg.gate_en && clk_del && !clk_del_q |-> acc_bit)
      else $error("clock edge dropped with gate off");
   a_bit_count: assert property (meas_bit && !last_bit |=> bit_cnt == $past(bit_cnt) + 1'b1)
      else $error("accepted bit not counted");
   a_ignore_run: assert property (meas_bit && is_ign && !last_bit |=> err_cnt == $past(err_cnt))
      else $error("error counted inside constant run");
   a_lock_keep: assert property (locked && (st == ST_MEAS || st == ST_PULSE) && !resync_hit
      |=> locked)
      else $error("lock dropped during repeat");
   a_fail_hold: assert property (i_cfg.fail_hold && fail && st != ST_IDLE |=> fail)
      else $error("held fail verdict cleared");
   a_cycle_verdict: assert property (last_bit |=> vvalid ##1 o_status.verdict_valid)
      else $error("no verdict after cycle end");
endmodule : bec_checker

// >>> verif/bec_uut_model.sv
// behavioural unit under test: free-running bit clock, prbs data, gate
`timescale 1ns/10ps
module bec_uut_model (
   input  wire logic i_err_en,
   input  wire logic i_const,
   input  wire logic i_gate_en,
   input  wire logic i_gate_pos,
   input  wire logic [3:0] i_lag,
   output logic      o_clk,
   output logic      o_data,
   output logic      o_gate
);
   logic [8:0] lfsr;
   logic [5:0] bitn;
   logic [15:0] gh;
   logic        take;

   // free-running 200 ns bit clock, phase unrelated to the main clock
   initial begin
      o_clk  = 1'h0;
      o_data = 1'h0;
      o_gate = 1'h1;
      lfsr   = 9'h1ff;
      bitn   = 6'h00;
      gh     = 16'hffff;
      take   = 1'h1;
      #7.3;
      forever begin
         #100 o_clk = ~o_clk;
      end
   end

   // new bit on the falling clock so it is stable at the rise
   always @(negedge o_clk) begin
      // sequence advances only on bits the checker will accept, so it stays continuous
      gh   = {gh[14:0], ~bitn[4]};
      take = !i_gate_en || (gh[i_lag] == i_gate_pos);
      if (take) begin
         lfsr <= {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
      bitn   <= bitn + 6'h01;
      o_gate <= ~bitn[4];
      // one flip per 64 bits in the low-gate half; forced ones on request
      // gated-out bits carry the inverse so that using them would show errors
      o_data <= i_const | (lfsr[8] ^ lfsr[4] ^ (i_err_en & (bitn == 6'h18)) ^ ~take);
   end
endmodule : bec_uut_model

// >>> verif/testbench.sv
// self-checking bench for the bit error rate checker
`timescale 1ns/10ps
module testbench;
   import bec_pkg::*;

   // row fields: gate, polarity, clk delay, gate delay, bit delay, errors,
   // constant run, ignore, fail hold, expected fail, cycle count
   typedef struct packed {
      logic       gate_en;
      logic       gate_pos;
      logic       clk_dly_en;
      logic       gate_dly_en;
      logic       bit_dly_en;
      logic       err;
      logic       cnst;
      logic       ign;
      logic       hold;
      logic       fail;
      logic [1:0] cyc;
   } bec_row_t;

   localparam int       T_MAX = 90000;
   localparam bec_row_t ROWS [10] = '{12'h002, 12'h045, 12'hc41, 12'h845, 12'hd41,
                                      12'h201, 12'h081, 12'h031, 12'h025, 12'h04f};

   logic      i_mclk;
   logic      i_rst_b;
   logic      i_trig;
   bec_cfg_t  cfg;
   bec_stat_t o_status;
   logic      o_meas_active;
   logic      o_result_pulse;
   logic      m_clk;
   logic      m_data;
   logic      m_gate;
   logic      err_en;
   logic      const_on;
   logic      prev_act;
   int        fails;
   int        num_checks;
   int        tcyc;
   int        ncyc;
   int        hw;
   int        npulse;
   int        nshort;
   int        fall_cyc;
   int        gap;

   bec_checker #(.DLY_DEPTH(16)) i_bec_checker (
      .i_mclk         (i_mclk),
      .i_rst_b        (i_rst_b),
      .i_meas_clk     (m_clk),
      .i_data         (m_data),
      .i_gate         (m_gate),
      .i_trig         (i_trig),
      .i_cfg          (cfg),
      .o_meas_active  (o_meas_active),
      .o_result_pulse (o_result_pulse),
      .o_status       (o_status)
   );

   bec_uut_model i_bec_uut_model (
      .i_err_en (err_en),
      .i_const  (const_on),
      .i_gate_en (cfg.gate_en),
      .i_gate_pos (cfg.gate_pos),
      .i_lag    (cfg.gate_dly_en ? cfg.gate_dly : 4'h0),
      .o_clk    (m_clk),
      .o_data   (m_data),
      .o_gate   (m_gate)
   );

   // 40 MHz main clock
   initial begin
      i_mclk = 1'h0;
      forever begin
         #12.5 i_mclk = ~i_mclk;
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic results;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   // hang guard
   always @(posedge i_mclk) begin
      tcyc++;
      if (tcyc == T_MAX) begin
         fails++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end

   // pulse widths and pulse-fall to active-fall spacing
   always @(negedge i_mclk) begin
      if (o_result_pulse === 1'h1) begin
         hw++;
      end else begin
         if (hw == PULSE_CYC) begin
            npulse++;
            fall_cyc = ncyc;
         end else if (hw != 0) begin
            nshort++;
         end
         hw = 0;
      end
      if (prev_act === 1'h1 && o_meas_active === 1'h0) begin
         gap = ncyc - fall_cyc;
      end
      prev_act = o_meas_active;
      ncyc++;
   end

   task automatic pulse_trig;
      i_trig = 1'h1;
      @(negedge i_mclk);
      i_trig = 1'h0;
   endtask : pulse_trig

   task automatic run_row(input bec_row_t r);
      int n;
      n                = 0;
      cfg              = '0;
      cfg.gate_en      = r.gate_en;
      cfg.gate_pos     = r.gate_pos;
      cfg.clk_dly_en   = r.clk_dly_en;
      cfg.clk_dly      = 4'h2;
      cfg.gate_dly_en  = r.gate_dly_en;
      cfg.gate_dly     = 4'h2;
      cfg.bit_dly_en   = r.bit_dly_en;
      cfg.bit_dly      = 5'h09;
      cfg.ign_en       = r.ign;
      cfg.ign_val      = 1'h1;
      cfg.fail_hold    = r.hold;
      cfg.total_bits   = 24'h00_0100;
      cfg.cycles       = {6'h00, r.cyc};
      err_en           = r.err;
      npulse           = 0;
      nshort           = 0;
      repeat (20) @(negedge i_mclk);
      pulse_trig();
      while (o_meas_active !== 1'h1 && n < 50) begin
         @(negedge i_mclk);
         n++;
      end
      check(n, T1_CYC, "active rise latency");
      repeat (400) @(negedge i_mclk);
      check(o_status.busy, 1'h1, "busy while measuring");
      if (!r.gate_en) begin
         check(o_status.locked, 1'h1, "locked");
      end
      pulse_trig();
      if (r.cnst) begin
         const_on = 1'h1;
         repeat (1600) @(negedge i_mclk);
         const_on = 1'h0;
      end
      n = 0;
      while (o_meas_active !== 1'h0 && n < 20000) begin
         @(negedge i_mclk);
         n++;
      end
      repeat (20) @(negedge i_mclk);
      check(gap, T2_CYC, "pulse fall to active fall");
      check(npulse, r.cyc, "result pulses");
      check(o_status.cycle_done, cfg.cycles, "cycles done");
      check(o_status.bit_cnt, cfg.total_bits, "bit count");
      check(o_status.fail, r.fail, "verdict");
      check(o_status.err_cnt != 0, r.fail, "errors seen");
      check(nshort != 0, r.clk_dly_en, "delayed clock on pulse pin");
      check(o_meas_active, 1'h0, "extra trigger ignored");
   endtask : run_row

   // main sequence
   initial begin
      i_rst_b  = 1'h0;
      i_trig   = 1'h0;
      cfg      = '0;
      err_en   = 1'h0;
      const_on = 1'h0;
      repeat (4) @(negedge i_mclk);
      check({o_meas_active, o_result_pulse, o_status}, 64'h0, "outputs in reset");
      i_rst_b = 1'h1;
      for (int k = 0; k < 10; k++) begin
         run_row(ROWS[k]);
         $display("row test %0d done", k);
      end
      // reset in mid-measurement, then recover
      pulse_trig();
      repeat (100) @(negedge i_mclk);
      i_rst_b = 1'h0;
      repeat (4) @(negedge i_mclk);
      check({o_meas_active, o_result_pulse, o_status}, 64'h0, "mid-run reset");
      i_rst_b = 1'h1;
      @(negedge i_mclk);
      check({o_meas_active, o_result_pulse, o_status}, 64'h0, "after release");
      run_row(ROWS[0]);
      $display("reset test done");
      results();
   end
endmodule : testbench
